// ---- bench/feature_settings_coalescing_tb_top.sv ----
// self-checking bench for the feature settings block
// assumes fsc_feature_ctrl with short prescaler parameters
`timescale 1ns/1ps
`include "fsc_map.vh"

module feature_settings_coalescing_tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic nonvol = 1'b0;
    logic rec_start = 1'b0;
    logic rec_end = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [3:0] post = 4'h0;
    logic [3:0] err = 4'h0;
    logic [3:0] ring = 4'h0;
    wire [3:0] db;
    wire [3:0] irq;
    wire [31:0] rdata;
    wire cache_en;
    wire timeout;
    wire rec_act;
    wire [15:0] cplq;
    wire [15:0] subq;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    fsc_feature_ctrl #(.STEP_CYC(4), .RETRY_STEPS(2)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .cache_nonvolatile_in(nonvol), .cache_enable_out(cache_en),
        .recovery_start_in(rec_start), .recovery_end_in(rec_end), .recovery_active_out(rec_act),
        .recovery_timeout_out(timeout), .cpl_queues_allocated_out(cplq), .sub_queues_allocated_out(subq),
        .cpl_post_in(post), .cpl_error_in(err), .cq_head_db_in(db), .vec_irq_out(irq));

    fsc_host_model u_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .irq_in(irq), .ring_in(ring), .db_out(db));

    // ****
    // shared tasks
    // ****
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // start recovery, count cycles to the timeout pulse (60 = none)
    task rec(output int k);
        @(posedge ref_clk_in);
        rec_start <= 1'b1;
        @(posedge ref_clk_in);
        rec_start <= 1'b0;
        k = 0;
        #1;
        while (timeout !== 1'b1 && k < 60) begin
            @(posedge ref_clk_in);
            #1 k++;
        end
    endtask

    // n back-to-back entries on mask m; k = cycles from last entry to interrupt
    task burst(input logic [3:0] m, input int n, input logic e, output int k);
        logic early;
        early = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_in);
            post <= m;
            err <= e ? m : 4'h0;
            #1 if (i > 0 && (irq & m) !== 4'h0) early = 1'b1;
        end
        @(posedge ref_clk_in);
        post <= 4'h0;
        err <= 4'h0;
        k = 0;
        #1;
        while ((irq & m) === 4'h0 && k < 2000) begin
            @(posedge ref_clk_in);
            #1 k++;
        end
        chk({31'h0000_0000, early}, 32'h0000_0000);
    endtask

    task wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task t_defaults;
        rd(`FSC_OFS_RECOVERY, 32'h0000_0000);
        rd(`FSC_OFS_CACHE, 32'h0000_0000);
        rd(`FSC_OFS_QUEUES, 32'h0007_0007);
        rd(`FSC_OFS_COALESCE, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
    endtask

    task t_queues;
        wr(`FSC_OFS_QUEUES, 32'h0002_0009);
        rd(`FSC_OFS_QUEUES, 32'h0002_0007);
        chk({cplq, subq}, 32'h0002_0007);
        wr(`FSC_OFS_QUEUES, 32'h0001_0001);
        rd(`FSC_OFS_QUEUES, 32'h0002_0007);
        chk({cplq, subq}, 32'h0002_0007);
    endtask

    task t_cache;
        wr(`FSC_OFS_CACHE, 32'h0000_0001);
        chk(cache_en, 1);
        rd(`FSC_OFS_CACHE, 32'h0000_0001);
        wr(`FSC_OFS_CACHE, 32'h0000_0000);
        chk(cache_en, 0);
        @(posedge ref_clk_in) nonvol <= 1'b1;
        @(posedge ref_clk_in) #1 chk(cache_en, 1);
        rd(`FSC_OFS_STATUS, 32'h0000_000b);
        @(posedge ref_clk_in) nonvol <= 1'b0;
    endtask

    task t_recovery;
        int k;
        wr(`FSC_OFS_RECOVERY, 32'h0000_0001);
        rd(`FSC_OFS_RECOVERY, 32'h0000_0001);
        rec(k);
        chk(k, 8);
        wr(`FSC_OFS_RECOVERY, 32'h0000_0000);
        rec(k);
        chk(k, 60);
        chk(rec_act, 1);
        // a zero limit runs until the command itself ends recovery
        @(posedge ref_clk_in) rec_end <= 1'b1;
        @(posedge ref_clk_in) rec_end <= 1'b0;
        #1 chk(rec_act, 0);
        rd(`FSC_OFS_STATUS, 32'h0000_0002);
    endtask

    task t_coal;
        int k;
        wr(`FSC_OFS_COALESCE, 32'h0000_3002);
        rd(`FSC_OFS_COALESCE, 32'h0000_3002);
        burst(4'h1, 1, 1'b0, k);
        chk(k, 0);
        burst(4'h2, 3, 1'b0, k);
        chk(k, 0);
        burst(4'h4, 1, 1'b1, k);
        chk(k, 0);
        wr(`FSC_OFS_COALESCE, 32'h0000_030a);
        burst(4'h4, 1, 1'b0, k);
        chk(k >= 8 && k <= 12, 1);
        wr(`FSC_OFS_COALESCE, 32'h0000_000a);
        burst(4'h4, 1, 1'b0, k);
        chk(k, 0);
        // one entry, then a doorbell: the next single entry must not fire
        wr(`FSC_OFS_COALESCE, 32'h0000_4001);
        @(posedge ref_clk_in) post <= 4'h8;
        @(posedge ref_clk_in) post <= 4'h0;
        ring <= 4'h8;
        @(posedge ref_clk_in) ring <= 4'h0;
        @(posedge ref_clk_in);
        burst(4'h8, 2, 1'b0, k);
        chk(k, 0);
    endtask

    // cut a hang short
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up;
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_defaults;
        t_queues;
        t_cache;
        t_recovery;
        t_coal;
        wrap_up;
    end
endmodule // feature_settings_coalescing_tb_top

bind fsc_feature_ctrl fsc_chk #(.STEP_CYC(STEP_CYC), .RETRY_STEPS(RETRY_STEPS)) u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .cache_nonvolatile_in(cache_nonvolatile_in), .cache_enable_out(cache_enable_out),
    .recovery_start_in(recovery_start_in), .recovery_end_in(recovery_end_in),
    .recovery_active_out(recovery_active_out), .recovery_timeout_out(recovery_timeout_out),
    .cpl_queues_allocated_out(cpl_queues_allocated_out), .sub_queues_allocated_out(sub_queues_allocated_out),
    .cpl_post_in(cpl_post_in), .cpl_error_in(cpl_error_in), .cq_head_db_in(cq_head_db_in),
    .vec_irq_out(vec_irq_out));

// ---- bench/fsc_feature_ctrl_assertions.sv ----
// port-level checks for the feature settings block
// assumes a bind from the bench top, one clock, sync active-high reset
`timescale 1ns/1ps
`include "fsc_map.vh"

module fsc_chk #(
    parameter STEP_CYC = 4,
    parameter RETRY_STEPS = 2
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // cache and recovery
    input wire logic cache_nonvolatile_in,
    input wire logic cache_enable_out,
    input wire logic recovery_start_in,
    input wire logic recovery_end_in,
    input wire logic recovery_active_out,
    input wire logic recovery_timeout_out,
    // queues and interrupts
    input wire logic [15:0] cpl_queues_allocated_out,
    input wire logic [15:0] sub_queues_allocated_out,
    input wire logic [`FSC_NUM_VEC-1:0] cpl_post_in,
    input wire logic [`FSC_NUM_VEC-1:0] cpl_error_in,
    input wire logic [`FSC_NUM_VEC-1:0] cq_head_db_in,
    input wire logic [`FSC_NUM_VEC-1:0] vec_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ****
    // shadow of the settings, so checks need no peek inside
    // ****
    reg q_fixed;
    reg en;
    reg [7:0] tim;
    reg [7:0] agg_cnt;
    reg [15:0] lim;
    reg [15:0] cur_lim;
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            q_fixed <= 1'b0;
            en <= 1'b0;
            tim <= 8'h00;
            agg_cnt <= 8'h00;
            lim <= 16'h0000;
            cur_lim <= 16'h0000;
        end else begin
            if (reg_wr_in && reg_addr_in == `FSC_OFS_QUEUES)
                q_fixed <= 1'b1;
            if (reg_wr_in && reg_addr_in == `FSC_OFS_CACHE)
                en <= reg_wdata_in[0];
            if (reg_wr_in && reg_addr_in == `FSC_OFS_COALESCE) begin
                tim <= reg_wdata_in[15:8];
                agg_cnt <= reg_wdata_in[7:0];
            end
            if (reg_wr_in && reg_addr_in == `FSC_OFS_RECOVERY)
                lim <= reg_wdata_in[15:0];
            if (recovery_start_in)
                cur_lim <= lim;
        end
    end

    // ****
    // assertions
    // ****
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside its slot");
    a_queue_read: assert property (reg_rd_in && reg_addr_in == `FSC_OFS_QUEUES
        |=> reg_rdata_out == {cpl_queues_allocated_out, sub_queues_allocated_out})
        else $error("queue read differs from allocation");
    a_alloc_hold: assert property (q_fixed |=> $stable(cpl_queues_allocated_out)
        && $stable(sub_queues_allocated_out)) else $error("allocation moved");
    a_cache_ctrl: assert property (cache_enable_out == (en | cache_nonvolatile_in))
        else $error("cache enable wrong");
    a_admin_now: assert property (cpl_post_in[0] |=> vec_irq_out[0])
        else $error("admin entry delayed");
    a_admin_only: assert property (!cpl_post_in[0] |=> !vec_irq_out[0])
        else $error("admin interrupt without entry");
    a_error_now: assert property ((cpl_post_in & cpl_error_in) != 4'h0
        |=> (vec_irq_out & $past(cpl_post_in & cpl_error_in)) == $past(cpl_post_in & cpl_error_in))
        else $error("error entry coalesced");
    a_no_delay: assert property (cpl_post_in[2] && (tim == 8'h00 || agg_cnt == 8'h00) |=> vec_irq_out[2])
        else $error("entry delayed with coalescing off");
    a_timeout_end: assert property (recovery_timeout_out |-> $past(recovery_active_out)
        && !recovery_active_out) else $error("timeout without running timer");
    a_zero_limit: assert property (recovery_timeout_out |-> cur_lim != 16'h0000)
        else $error("timeout with zero limit");
endmodule // fsc_chk

// ---- bench/fsc_host_model.sv ----
// host driver model: acknowledges interrupts by moving the queue head
// assumes the bench may also ring a doorbell on its own
`timescale 1ns/1ps

module fsc_host_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // interrupts and manual doorbells
    input wire logic [3:0] irq_in,
    input wire logic [3:0] ring_in,
    output logic [3:0] db_out
);
    // a fast host: one cycle from interrupt to head doorbell
    always @(posedge ref_clk_in) begin
        if (rst_in)
            db_out <= 4'h0;
        else
            db_out <= irq_in | ring_in;
    end
endmodule // fsc_host_model

// ---- hdl/fsc_coal_vec.v ----
// one interrupt vector's coalescing engine
// assumes a one-cycle 100 us tick shared by all vectors
`timescale 1ns/1ps

module fsc_coal_vec (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // settings
    input wire bypass_in,
    input wire [7:0] agg_time_in,
    input wire [7:0] aggregation_entry_count_in,
    // events
    input wire tick_in,
    input wire post_in,
    input wire error_in,
    input wire head_db_in,
    // interrupt
    output reg irq_out
);

    // ********************************
    // pending state
    // ********************************
    reg [8:0] pend_cnt;
    reg [7:0] elapsed;
    wire pending;
    wire [8:0] next_cnt;
    wire cnt_hit;
    wire time_hit;
    wire immediate;
    wire fire;

    assign pending = (pend_cnt != 9'h000);
    assign next_cnt = pend_cnt + {8'h00, post_in};
    // threshold is zero based: fire once count exceeds it
    assign cnt_hit = (next_cnt > {1'b0, aggregation_entry_count_in});
    // elapsed counts whole ticks, so the delay never runs past the setting
    assign time_hit = pending & tick_in & ((elapsed + 8'h01) >= agg_time_in);
    assign immediate = post_in & (bypass_in | error_in | (agg_time_in == 8'h00));
    assign fire = immediate | ((pending | post_in) & cnt_hit) | time_hit;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            pend_cnt <= 9'h000;
            elapsed <= 8'h00;
            irq_out <= 1'b0;
        end else begin
            irq_out <= fire;
            if (fire) begin
                pend_cnt <= 9'h000;
                elapsed <= 8'h00;
            end else if (head_db_in) begin
                // host is already draining this queue; may delay further
                pend_cnt <= {8'h00, post_in};
                elapsed <= 8'h00;
            end else begin
                pend_cnt <= next_cnt;
                if (pending & tick_in & (elapsed != 8'hff)) begin
                    elapsed <= elapsed + 8'h01;
                end
            end
        end
    end

endmodule // fsc_coal_vec

// ---- hdl/fsc_feature_ctrl.v ----
// feature settings holder: error recovery, write cache, queue count, coalescing
// assumes one clock, synchronous active-high reset, and a plain register port
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "fsc_map.vh"

module fsc_feature_ctrl #(
    parameter STEP_CYC = `FSC_STEP_CYC,
    parameter RETRY_STEPS = `FSC_RETRY_STEPS
) (
    // clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // write cache
    input wire cache_nonvolatile_in,
    output wire cache_enable_out,
    // error recovery
    input wire recovery_start_in,
    input wire recovery_end_in,
    output wire recovery_active_out,
    output reg recovery_timeout_out,
    // queue allocation
    output wire [15:0] cpl_queues_allocated_out,
    output wire [15:0] sub_queues_allocated_out,
    // completion events and interrupts, vector 0 is admin
    input wire [`FSC_NUM_VEC-1:0] cpl_post_in,
    input wire [`FSC_NUM_VEC-1:0] cpl_error_in,
    input wire [`FSC_NUM_VEC-1:0] cq_head_db_in,
    output wire [`FSC_NUM_VEC-1:0] vec_irq_out
);

    // ********************************
    // held settings
    // ********************************
    reg [15:0] retry_time_limit;
    reg volatile_cache_enable;
    reg [15:0] cpl_queues_allocated;
    reg [15:0] sub_queues_allocated;
    reg queues_fixed;
    reg [7:0] agg_time;
    reg [7:0] aggregation_entry_count;

    wire wr_recovery;
    wire wr_cache;
    wire wr_queues;
    wire wr_coalesce;
    wire [15:0] req_cplq;
    wire [15:0] req_subq;

    assign wr_recovery = reg_wr_in & (reg_addr_in == `FSC_OFS_RECOVERY);
    assign wr_cache = reg_wr_in & (reg_addr_in == `FSC_OFS_CACHE);
    assign wr_queues = reg_wr_in & (reg_addr_in == `FSC_OFS_QUEUES);
    assign wr_coalesce = reg_wr_in & (reg_addr_in == `FSC_OFS_COALESCE);
    assign req_cplq = reg_wdata_in[`FSC_CPLQ_MSB:`FSC_CPLQ_LSB];
    assign req_subq = reg_wdata_in[`FSC_SUBQ_MSB:`FSC_SUBQ_LSB];

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            retry_time_limit <= `FSC_RST_RETRY;
            volatile_cache_enable <= `FSC_RST_CACHE_EN;
            agg_time <= `FSC_RST_TIME;
            aggregation_entry_count <= `FSC_RST_CNT;
        end else begin
            if (wr_recovery) begin
                retry_time_limit <= reg_wdata_in[`FSC_RETRY_MSB:`FSC_RETRY_LSB];
            end
            if (wr_cache) begin
                volatile_cache_enable <= reg_wdata_in[`FSC_CACHE_EN_BIT];
            end
            if (wr_coalesce) begin
                agg_time <= reg_wdata_in[`FSC_TIME_MSB:`FSC_TIME_LSB];
                aggregation_entry_count <= reg_wdata_in[`FSC_CNT_MSB:`FSC_CNT_LSB];
            end
        end
    end

    // ********************************
    // write cache
    // ********************************
    // a power-safe cache stays on whatever software asks
    assign cache_enable_out = cache_nonvolatile_in | volatile_cache_enable;

    // ********************************
    // queue allocation
    // ********************************
    // the first request after reset fixes the counts; later ones change nothing,
    // since queues may already exist by then
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            cpl_queues_allocated <= `FSC_MAX_CPLQ;
            sub_queues_allocated <= `FSC_MAX_SUBQ;
            queues_fixed <= 1'b0;
        end else if (wr_queues & ~queues_fixed) begin
            queues_fixed <= 1'b1;
            // zero based, so zero already means one queue
            if (req_cplq > `FSC_MAX_CPLQ) begin
                cpl_queues_allocated <= `FSC_MAX_CPLQ;
            end else begin
                cpl_queues_allocated <= req_cplq;
            end
            if (req_subq > `FSC_MAX_SUBQ) begin
                sub_queues_allocated <= `FSC_MAX_SUBQ;
            end else begin
                sub_queues_allocated <= req_subq;
            end
        end
    end

    assign cpl_queues_allocated_out = cpl_queues_allocated;
    assign sub_queues_allocated_out = sub_queues_allocated;

    // ********************************
    // error recovery timer
    // ********************************
    // own prescaler restarted at each start, so the limit is never cut short
    reg rec_active;
    reg [15:0] rec_limit;
    reg [15:0] rec_units;
    reg [15:0] rec_steps;
    reg [15:0] rec_cyc;
    wire rec_step;
    wire rec_unit;

    assign rec_step = rec_active & (rec_cyc == (STEP_CYC[15:0] - 16'h0001));
    assign rec_unit = rec_step & (rec_steps == (RETRY_STEPS[15:0] - 16'h0001));

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            rec_active <= 1'b0;
            rec_limit <= 16'h0000;
            rec_units <= 16'h0000;
            rec_steps <= 16'h0000;
            rec_cyc <= 16'h0000;
            recovery_timeout_out <= 1'b0;
        end else begin
            recovery_timeout_out <= 1'b0;
            if (recovery_start_in) begin
                rec_active <= 1'b1;
                rec_limit <= retry_time_limit;
                rec_units <= 16'h0000;
                rec_steps <= 16'h0000;
                rec_cyc <= 16'h0000;
            end else if (recovery_end_in) begin
                rec_active <= 1'b0;
            end else if (rec_active) begin
                if (rec_step) begin
                    rec_cyc <= 16'h0000;
                end else begin
                    rec_cyc <= rec_cyc + 16'h0001;
                end
                if (rec_unit) begin
                    rec_steps <= 16'h0000;
                    rec_units <= rec_units + 16'h0001;
                    // zero limit: keep retrying without end
                    if ((rec_limit != 16'h0000) && ((rec_units + 16'h0001) == rec_limit)) begin
                        rec_active <= 1'b0;
                        recovery_timeout_out <= 1'b1;
                    end
                end else if (rec_step) begin
                    rec_steps <= rec_steps + 16'h0001;
                end
            end
        end
    end

    assign recovery_active_out = rec_active;

    // ********************************
    // shared aggregation tick
    // ********************************
    reg [15:0] tick_cyc;
    reg agg_tick;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            tick_cyc <= 16'h0000;
            agg_tick <= 1'b0;
        end else if (tick_cyc == (STEP_CYC[15:0] - 16'h0001)) begin
            tick_cyc <= 16'h0000;
            agg_tick <= 1'b1;
        end else begin
            tick_cyc <= tick_cyc + 16'h0001;
            agg_tick <= 1'b0;
        end
    end

    // ********************************
    // per-vector coalescing
    // ********************************
    genvar v;
    generate
        for (v = 0; v < `FSC_NUM_VEC; v = v + 1) begin : g_vec
            fsc_coal_vec u_vec (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .bypass_in(v == 0),
                .agg_time_in(agg_time),
                .aggregation_entry_count_in(aggregation_entry_count),
                .tick_in(agg_tick),
                .post_in(cpl_post_in[v]),
                .error_in(cpl_error_in[v]),
                .head_db_in(cq_head_db_in[v]),
                .irq_out(vec_irq_out[v])
            );
        end
    endgenerate

    // ********************************
    // register reads
    // ********************************
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (reg_addr_in)
            `FSC_OFS_RECOVERY: begin
                next_rdata[`FSC_RETRY_MSB:`FSC_RETRY_LSB] = retry_time_limit;
            end
            `FSC_OFS_CACHE: begin
                next_rdata[`FSC_CACHE_EN_BIT] = volatile_cache_enable;
            end
            `FSC_OFS_QUEUES: begin
                next_rdata[`FSC_CPLQ_MSB:`FSC_CPLQ_LSB] = cpl_queues_allocated;
                next_rdata[`FSC_SUBQ_MSB:`FSC_SUBQ_LSB] = sub_queues_allocated;
            end
            `FSC_OFS_COALESCE: begin
                next_rdata[`FSC_TIME_MSB:`FSC_TIME_LSB] = agg_time;
                next_rdata[`FSC_CNT_MSB:`FSC_CNT_LSB] = aggregation_entry_count;
            end
            `FSC_OFS_STATUS: begin
                next_rdata[0] = cache_enable_out;
                next_rdata[1] = queues_fixed;
                next_rdata[2] = rec_active;
                next_rdata[3] = cache_nonvolatile_in;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule // fsc_feature_ctrl

// ---- hdl/fsc_map.vh ----
// constants for the feature settings and interrupt coalescing block
// assumes one 200 MHz clock and a plain one-cycle register port
//
// Operation
// - retry time limit is bits 15:0, counted in 100 ms units for time-limited commands
// - a retry time limit of zero means recovery never times out
// - reading a feature returns its currently held attribute fields in dword 0 layout
// - the volatile write cache control feature is always present here
// - cache enable bit 0 set turns the volatile cache on, clear turns it off
// - a cache guaranteed safe on power loss ignores the enable setting
// - allocated queue counts stay fixed until the next reset
// - request bits 31:16 give zero-based completion queue count, admin excluded
// - request bits 15:0 give zero-based submission queue count, admin excluded
// - allocated counts read back zero-based, completion in 31:16, submission in 15:0
// - allocation may be fewer than requested when the device lacks queues
// - coalescing applies only to I/O vectors, never the admin vector
// - completions with an error interrupt at once, without coalescing
// - a completion head doorbell restarts that vector's time and entry count
// - aggregation time bits 15:8 in 100 us steps bounds the interrupt delay
// - aggregation time zero means no delay; it resets to zero
// - one shared 100 us tick drives every vector's own aggregation timer
// - threshold bits 7:0 are a zero-based entry count; it resets to zero
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// ********************************
// register offsets (byte addresses)
// ********************************
`define FSC_OFS_RECOVERY 8'h00
`define FSC_OFS_CACHE 8'h04
`define FSC_OFS_QUEUES 8'h08
`define FSC_OFS_COALESCE 8'h0c
`define FSC_OFS_STATUS 8'h10

// ********************************
// field positions
// ********************************
`define FSC_RETRY_MSB 15
`define FSC_RETRY_LSB 0
`define FSC_CACHE_EN_BIT 0
`define FSC_CPLQ_MSB 31
`define FSC_CPLQ_LSB 16
`define FSC_SUBQ_MSB 15
`define FSC_SUBQ_LSB 0
`define FSC_TIME_MSB 15
`define FSC_TIME_LSB 8
`define FSC_CNT_MSB 7
`define FSC_CNT_LSB 0

// ********************************
// reset values
// ********************************
`define FSC_RST_RETRY 16'h0000
`define FSC_RST_CACHE_EN 1'b0
`define FSC_RST_TIME 8'h00
`define FSC_RST_CNT 8'h00
`define FSC_MAX_CPLQ 16'h0007
`define FSC_MAX_SUBQ 16'h0007

// ********************************
// timing and vector count
// ********************************
`define FSC_CLK_MHZ 200
`define FSC_STEP_US 100
`define FSC_STEP_CYC (`FSC_STEP_US * `FSC_CLK_MHZ)
`define FSC_RETRY_MS 100
`define FSC_RETRY_STEPS ((`FSC_RETRY_MS * 1000) / `FSC_STEP_US)
`define FSC_NUM_VEC 4

`endif
